//--- inc/bda_link_if.sv
// Byte command link between the host controller and the window device
`timescale 1ns/1ps
`default_nettype none
interface bda_link_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;

    modport dev (
        input req,
        input we,
        input addr,
        input wdata,
        output ack,
        output rdata
    );

    modport host (
        output req,
        output we,
        output addr,
        output wdata,
        input ack,
        input rdata
    );
endinterface : bda_link_if
`default_nettype wire

//--- inc/bda_pkg.sv
// Constants and types shared by the block-data window device and its host
//
// Summary of operation
// - Unlocked class-select write picks data class
// - Block select holds 32-byte block number
// - Locked block select 0x01 shows maker block
// - Locked: class and block select refuse access
// - Unlocked 0x40-0x5F map selected block bytes
// - Locked window shows only maker info block
// - Permissions follow lock state
// - Host writes 255 minus byte sum
// - Block commits only after correct checksum
// - Locked checksum covers eight maker bytes
// - Access-control 0x00 enables window; locked refused
// - Addresses 0x62-0x7F reserved, no function
// - Reset reloads RAM defaults; NVM persists
// - Host edits data in configuration-update mode
// - Offset N maps to block N/32, byte N%32
// - Writes beyond 32 bytes are discarded
// - Written values accepted without range checks
// - Ships unlocked; key changes only unlocked
// - Seal subcommand sets sealed flag within 2s
// - Host sends both key words back to back
// - Host sends low word first, bytes swapped
// - Correct key sequence clears the sealed flag
// - Key words differ from subcommand codes
package bda_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Command-space addresses on the link
    localparam logic [7:0] CMD_CTL_LO = 8'h00;
    localparam logic [7:0] CMD_CTL_HI = 8'h01;
    localparam logic [7:0] CMD_CLASS = 8'h3E;
    localparam logic [7:0] CMD_BLOCK = 8'h3F;
    localparam logic [7:0] CMD_WIN_FIRST = 8'h40;
    localparam logic [7:0] CMD_WIN_LAST = 8'h5F;
    localparam logic [7:0] CMD_CSUM = 8'h60;
    localparam logic [7:0] CMD_ACC = 8'h61;
    localparam logic [7:0] CMD_RSV_FIRST = 8'h62;
    localparam logic [7:0] CMD_RSV_LAST = 8'h7F;

    // Codes and sizes
    localparam int BLOCK_BYTES = 32;
    localparam int MAKER_BYTES = 8;
    localparam logic [7:0] ACC_ENABLE_CODE = 8'h00;
    localparam logic [7:0] MAKER_BLOCK_CODE = 8'h01;
    localparam logic [15:0] SUB_SEAL = 16'h0020;
    localparam int SS_BIT = 13;
    localparam logic [5:0] WCOUNT_LIMIT = 6'h20;

    // Supported data classes; the first four are RAM backed
    localparam logic [7:0] CLS_SAFETY = 8'h02;
    localparam logic [7:0] CLS_CHG_TERM = 8'h24;
    localparam logic [7:0] CLS_DISCHARGE = 8'h31;
    localparam logic [7:0] CLS_POWER = 8'h44;
    localparam logic [7:0] CLS_MAKER = 8'h3A;
    localparam logic [7:0] CLS_STATE = 8'h52;
    localparam logic [7:0] CLS_CALIB = 8'h68;
    localparam logic [7:0] CLS_KEY = 8'h70;
    localparam logic [2:0] SLOT_MAKER = 3'h4;
    localparam logic [2:0] SLOT_KEY = 3'h7;
    localparam logic [8:0] RAM_LAST = 9'h0FF;

    // Seal delay: longest time, rounded down
    localparam int SEAL_TIME_S = 2;
    localparam int CLK_HZ = 100_000_000;
    localparam int SEAL_MAX_CYCLES = SEAL_TIME_S * CLK_HZ;

    ////////////////////////////////////////////////////////////////////////
    // Host-side Wishbone register offsets and fields
    localparam logic [7:0] HR_CTRL = 8'h00;
    localparam logic [7:0] HR_DATA = 8'h04;
    localparam logic [7:0] HR_STAT = 8'h08;
    localparam logic [7:0] HR_KEY = 8'h0C;
    localparam int HC_CFG_BIT = 8;
    localparam int HS_BUSY_BIT = 0;
    localparam int HS_REFUSED_BIT = 1;
    localparam int HS_CFG_BIT = 2;

    typedef enum logic [2:0] {
        OP_WRITE,
        OP_READ,
        OP_CSUM,
        OP_UNLOCK,
        OP_CTLWORD
    } bda_op_type;

endpackage : bda_pkg

//--- logic/bda_device.sv
// Block-data window, checksum commit and lock state of the device end
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bda_device #(
    parameter int SEAL_CYCLES = bda_pkg::SEAL_MAX_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    bda_link_if.dev link,
    output logic sealed_o,
    output logic busy_o
);

    if (SEAL_CYCLES < 1)
    begin : g_bad_seal
        $error("SEAL_CYCLES must be at least one");
    end

    typedef enum logic [2:0] {
        ST_INIT,
        ST_IDLE,
        ST_LOAD,
        ST_STORE
    } bda_dstate_type;

    typedef struct packed {
        bda_dstate_type state;
        logic [8:0] idx;
        logic [7:0] cls;
        logic [7:0] blk;
        logic acc_en;
        logic sealed;
        logic maker_sel;
        logic [bda_pkg::BLOCK_BYTES-1:0][7:0] win;
        logic [5:0] wcount;
        logic [7:0] ctl_lo;
        logic key_stage;
        logic seal_pend;
        logic [31:0] seal_cnt;
        logic ack;
        logic [7:0] rdata;
        logic busy;
    } bda_dev_type;

    bda_dev_type r_reg;
    bda_dev_type r_next;
    logic [7:0] mem [0:511];
    logic mem_we;
    logic [8:0] mem_wa;
    logic [7:0] mem_wd;

    ////////////////////////////////////////////////////////////////////////
    // Class code to storage slot; bit 3 flags a supported class
    function automatic logic [3:0] class_slot(input logic [7:0] c);
        unique case (c)
            bda_pkg::CLS_SAFETY: class_slot = 4'h8;
            bda_pkg::CLS_CHG_TERM: class_slot = 4'h9;
            bda_pkg::CLS_DISCHARGE: class_slot = 4'hA;
            bda_pkg::CLS_POWER: class_slot = 4'hB;
            bda_pkg::CLS_MAKER: class_slot = 4'hC;
            bda_pkg::CLS_STATE: class_slot = 4'hD;
            bda_pkg::CLS_CALIB: class_slot = 4'hE;
            bda_pkg::CLS_KEY: class_slot = 4'hF;
            default: class_slot = 4'h0;
        endcase
    endfunction : class_slot

    // ROM defaults copied into the RAM-backed slots after reset
    function automatic logic [7:0] rom_default(input logic [8:0] a);
        unique case (a)
            9'h004: rom_default = 8'h32;
            9'h023: rom_default = 8'h63;
            9'h024: rom_default = 8'h5F;
            9'h025: rom_default = 8'h64;
            9'h026: rom_default = 8'h62;
            9'h040: rom_default = 8'h0A;
            9'h041: rom_default = 8'h0F;
            9'h042: rom_default = 8'h02;
            9'h043: rom_default = 8'h05;
            default: rom_default = 8'h00;
        endcase
    endfunction : rom_default

    function automatic logic [15:0] swap16(input logic [15:0] w);
        swap16 = {w[7:0], w[15:8]};
    endfunction : swap16

    ////////////////////////////////////////////////////////////////////////
    // Derived views: block address, sums, key words
    logic [3:0] slot_info;
    logic blk_ok;
    logic [8:0] blk_base;
    logic [7:0] win_sum;
    logic [7:0] maker_sum;
    logic [31:0] key_word;
    logic [4:0] off;
    logic [15:0] ctl_word;

    always_comb
    begin
        slot_info = class_slot(r_reg.cls);
        blk_ok = slot_info[3] && (r_reg.blk < 8'h02);
        blk_base = {slot_info[2:0], r_reg.blk[0], 5'h00};
        win_sum = 8'h00;
        for (int i = 0; i < bda_pkg::BLOCK_BYTES; i++)
            win_sum = win_sum + r_reg.win[i];
        maker_sum = 8'h00;
        for (int i = 0; i < bda_pkg::MAKER_BYTES; i++)
            maker_sum = maker_sum + mem[{bda_pkg::SLOT_MAKER, 1'b0, 5'(i)}];
        key_word = {mem[{bda_pkg::SLOT_KEY, 6'h00}],
            mem[{bda_pkg::SLOT_KEY, 6'h01}],
            mem[{bda_pkg::SLOT_KEY, 6'h02}],
            mem[{bda_pkg::SLOT_KEY, 6'h03}]};
        off = link.addr[4:0];
        ctl_word = {link.wdata, r_reg.ctl_lo};
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic; the link is only served in idle, so copies stall it
    always_comb
    begin
        r_next = r_reg;
        r_next.ack = 1'b0;
        mem_we = 1'b0;
        mem_wa = 9'h000;
        mem_wd = 8'h00;
        unique case (r_reg.state)
            ST_INIT:
            begin
                mem_we = 1'b1;
                mem_wa = r_reg.idx;
                mem_wd = rom_default(r_reg.idx);
                r_next.idx = r_reg.idx + 9'h001;
                if (r_reg.idx == bda_pkg::RAM_LAST)
                    r_next.state = ST_IDLE;
            end
            ST_LOAD:
            begin
                r_next.win[r_reg.idx[4:0]] = blk_ok ?
                    mem[blk_base | {4'h0, r_reg.idx[4:0]}] : 8'h00;
                r_next.idx = r_reg.idx + 9'h001;
                if (r_reg.idx[4:0] == 5'h1F)
                begin
                    r_next.state = ST_IDLE;
                    r_next.ack = 1'b1;
                end
            end
            ST_STORE:
            begin
                mem_we = blk_ok;
                mem_wa = blk_base | {4'h0, r_reg.idx[4:0]};
                mem_wd = r_reg.win[r_reg.idx[4:0]];
                r_next.idx = r_reg.idx + 9'h001;
                if (r_reg.idx[4:0] == 5'h1F)
                begin
                    r_next.state = ST_IDLE;
                    r_next.ack = 1'b1;
                end
            end
            ST_IDLE:
            begin
                if (link.req && !r_reg.ack)
                begin
                    r_next.ack = 1'b1;
                    r_next.rdata = 8'h00;
                    if (link.addr == bda_pkg::CMD_CTL_LO)
                    begin
                        r_next.rdata = 8'h00;
                        if (link.we)
                            r_next.ctl_lo = link.wdata;
                    end
                    else if (link.addr == bda_pkg::CMD_CTL_HI)
                    begin
                        r_next.rdata = {2'b00, r_reg.sealed, 5'h00};
                        if (link.we)
                        begin
                            r_next.key_stage = 1'b0;
                            if (!r_reg.sealed && ctl_word == bda_pkg::SUB_SEAL)
                            begin
                                r_next.seal_pend = 1'b1;
                                r_next.seal_cnt = 32'h0000_0000;
                            end
                            else if (r_reg.sealed && r_reg.key_stage &&
                                ctl_word == swap16(key_word[31:16]))
                                r_next.sealed = 1'b0;
                            else if (r_reg.sealed &&
                                ctl_word == swap16(key_word[15:0]))
                                r_next.key_stage = 1'b1;
                        end
                    end
                    else if (link.addr == bda_pkg::CMD_CLASS)
                    begin
                        r_next.rdata = r_reg.sealed ? 8'h00 : r_reg.cls;
                        if (link.we && !r_reg.sealed)
                            r_next.cls = link.wdata;
                    end
                    else if (link.addr == bda_pkg::CMD_BLOCK)
                    begin
                        r_next.rdata = r_reg.sealed ? 8'h00 : r_reg.blk;
                        if (link.we && r_reg.sealed)
                            r_next.maker_sel = (link.wdata ==
                                bda_pkg::MAKER_BLOCK_CODE);
                        else if (link.we)
                            r_next.blk = link.wdata;
                    end
                    else if (link.addr >= bda_pkg::CMD_WIN_FIRST &&
                        link.addr <= bda_pkg::CMD_WIN_LAST)
                    begin
                        if (!r_reg.sealed)
                            r_next.rdata = r_reg.win[off];
                        else if (r_reg.maker_sel && off < 5'(bda_pkg::MAKER_BYTES))
                            r_next.rdata = mem[{bda_pkg::SLOT_MAKER, 1'b0, off}];
                        if (link.we && !r_reg.sealed && r_reg.acc_en)
                        begin
                            r_next.win[off] = link.wdata;
                            if (r_reg.wcount <= bda_pkg::WCOUNT_LIMIT)
                                r_next.wcount = r_reg.wcount + 6'h01;
                        end
                    end
                    else if (link.addr == bda_pkg::CMD_CSUM)
                    begin
                        r_next.rdata = r_reg.sealed ? ~maker_sum : ~win_sum;
                        if (link.we && !r_reg.sealed)
                        begin
                            r_next.wcount = 6'h00;
                            if (r_reg.acc_en && r_reg.wcount != 6'h00 &&
                                r_reg.wcount <= bda_pkg::WCOUNT_LIMIT &&
                                link.wdata == ~win_sum)
                            begin
                                r_next.state = ST_STORE;
                                r_next.rdata = r_reg.rdata;
                                r_next.idx = 9'h000;
                                r_next.ack = 1'b0;
                            end
                        end
                    end
                    else if (link.addr == bda_pkg::CMD_ACC)
                    begin
                        if (link.we && !r_reg.sealed &&
                            link.wdata == bda_pkg::ACC_ENABLE_CODE)
                        begin
                            r_next.rdata = r_reg.rdata;
                            r_next.acc_en = 1'b1;
                            r_next.wcount = 6'h00;
                            r_next.state = ST_LOAD;
                            r_next.idx = 9'h000;
                            r_next.ack = 1'b0;
                        end
                    end
                end
            end
            default:
                r_next.state = ST_INIT;
        endcase

        // Seal delay runs beside the command handling
        if (r_reg.seal_pend)
        begin
            r_next.seal_cnt = r_reg.seal_cnt + 32'h0000_0001;
            if (r_reg.seal_cnt == 32'(SEAL_CYCLES - 1))
            begin
                r_next.seal_pend = 1'b0;
                r_next.sealed = 1'b1;
                r_next.acc_en = 1'b0;
                r_next.maker_sel = 1'b0;
                r_next.key_stage = 1'b0;
            end
        end
        r_next.busy = (r_next.state != ST_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; the device leaves reset unlocked
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            r_reg <= '0;
            r_reg.state <= ST_INIT;
            r_reg.busy <= 1'b1;
        end
        else if (ce_i)
            r_reg <= r_next;
    end

    // Storage array is never reset so NVM slots keep their contents
    always_ff @(posedge clk_i)
    begin
        if (ce_i && !rst_i && mem_we)
            mem[mem_wa] <= mem_wd;
    end

    assign link.ack = r_reg.ack;
    assign link.rdata = r_reg.rdata;
    assign sealed_o = r_reg.sealed;
    assign busy_o = r_reg.busy;

endmodule : bda_device
`default_nettype wire

//--- logic/bda_host.sv
// Host controller end: Wishbone registers in, byte commands out on the link
`timescale 1ns/1ps
`default_nettype none
module bda_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    bda_link_if.host link
);

    typedef enum logic [1:0] {
        HS_IDLE,
        HS_REQ,
        HS_GAP
    } bda_hstate_type;

    typedef struct packed {
        bda_hstate_type state;
        bda_pkg::bda_op_type op;
        logic [1:0] step;
        logic cfg;
        logic refused;
        logic [31:0] data;
        logic [31:0] key;
        logic [7:0] sum;
        logic [7:0] rbyte;
        logic req;
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [31:0] wb_dat;
        logic wb_ack;
    } bda_host_type;

    bda_host_type r_reg;
    bda_host_type r_next;
    logic [15:0] key_w0;
    logic [15:0] key_w1;
    logic last_step;
    logic data_write;

    ////////////////////////////////////////////////////////////////////////
    // Step address and data for the operation under way
    always_comb
    begin
        key_w0 = {r_reg.key[7:0], r_reg.key[15:8]};
        key_w1 = {r_reg.key[23:16], r_reg.key[31:24]};
        last_step = (r_reg.op == bda_pkg::OP_UNLOCK) ? (r_reg.step == 2'h3) :
            (r_reg.op == bda_pkg::OP_CTLWORD) ? (r_reg.step == 2'h1) : 1'b1;
        data_write = (r_reg.data[7:0] >= bda_pkg::CMD_WIN_FIRST &&
            r_reg.data[7:0] <= bda_pkg::CMD_ACC);
    end

    always_comb
    begin
        r_next = r_reg;
        r_next.wb_ack = 1'b0;
        unique case (r_reg.state)
            HS_IDLE: ;
            HS_REQ:
            begin
                if (link.ack)
                begin
                    r_next.req = 1'b0;
                    r_next.rbyte = link.rdata;
                    if (r_reg.op == bda_pkg::OP_WRITE &&
                        r_reg.addr >= bda_pkg::CMD_WIN_FIRST &&
                        r_reg.addr <= bda_pkg::CMD_WIN_LAST)
                        r_next.sum = r_reg.sum + r_reg.wdata;
                    if (r_reg.op == bda_pkg::OP_CSUM)
                        r_next.sum = 8'h00;
                    r_next.state = last_step ? HS_IDLE : HS_GAP;
                    r_next.step = r_reg.step + 2'h1;
                end
            end
            HS_GAP:
            begin
                // Next byte of a word; nothing else reaches the link between
                r_next.state = HS_REQ;
                r_next.req = 1'b1;
                r_next.we = 1'b1;
                r_next.addr = r_reg.step[0] ? bda_pkg::CMD_CTL_HI :
                    bda_pkg::CMD_CTL_LO;
                if (r_reg.op == bda_pkg::OP_UNLOCK)
                    r_next.wdata = r_reg.step[1] ?
                        (r_reg.step[0] ? key_w1[15:8] : key_w1[7:0]) :
                        (r_reg.step[0] ? key_w0[15:8] : key_w0[7:0]);
                else
                    r_next.wdata = r_reg.data[31:24];
            end
            default:
                r_next.state = HS_IDLE;
        endcase

        // Wishbone slave, one wait state, all offsets answered
        if (wb_cyc_i && wb_stb_i && !r_reg.wb_ack)
        begin
            r_next.wb_ack = 1'b1;
            r_next.wb_dat = 32'h0000_0000;
            if (wb_adr_i == bda_pkg::HR_STAT)
                r_next.wb_dat = {16'h0000, r_reg.rbyte, 5'h00,
                    r_reg.cfg, r_reg.refused, (r_reg.state != HS_IDLE)};
            else if (wb_adr_i == bda_pkg::HR_DATA)
                r_next.wb_dat = r_reg.data;
            else if (wb_adr_i == bda_pkg::HR_KEY)
                r_next.wb_dat = r_reg.key;
            if (wb_we_i && wb_adr_i == bda_pkg::HR_KEY && wb_sel_i == 4'hF)
                r_next.key = wb_dat_i;
            if (wb_we_i && wb_adr_i == bda_pkg::HR_DATA && wb_sel_i == 4'hF)
                r_next.data = wb_dat_i;
            if (wb_we_i && wb_adr_i == bda_pkg::HR_CTRL && wb_sel_i[1])
                r_next.cfg = wb_dat_i[bda_pkg::HC_CFG_BIT];
            if (wb_we_i && wb_adr_i == bda_pkg::HR_CTRL && wb_sel_i[0])
            begin
                r_next.refused = 1'b0;
                if (r_reg.state != HS_IDLE || wb_dat_i[2:0] > 3'h4 ||
                    (!wb_dat_i[bda_pkg::HC_CFG_BIT] &&
                    (wb_dat_i[2:0] == 3'h2 ||
                    (wb_dat_i[2:0] == 3'h0 && data_write))))
                    r_next.refused = 1'b1;
                else
                begin
                    r_next.op = bda_pkg::bda_op_type'(wb_dat_i[2:0]);
                    r_next.step = 2'h0;
                    r_next.state = HS_REQ;
                    r_next.req = 1'b1;
                    r_next.we = (wb_dat_i[2:0] != 3'h1);
                    r_next.addr = r_reg.data[7:0];
                    r_next.wdata = r_reg.data[15:8];
                    if (wb_dat_i[2:0] == 3'h2)
                    begin
                        r_next.addr = bda_pkg::CMD_CSUM;
                        r_next.wdata = 8'hFF - r_reg.sum;
                    end
                    else if (wb_dat_i[2:0] == 3'h3)
                    begin
                        r_next.addr = bda_pkg::CMD_CTL_LO;
                        r_next.wdata = key_w0[7:0];
                    end
                    else if (wb_dat_i[2:0] == 3'h4)
                    begin
                        r_next.addr = bda_pkg::CMD_CTL_LO;
                        r_next.wdata = r_reg.data[23:16];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            r_reg <= '0;
        else if (ce_i)
            r_reg <= r_next;
    end

    assign wb_dat_o = r_reg.wb_dat;
    assign wb_ack_o = r_reg.wb_ack;
    assign link.req = r_reg.req;
    assign link.we = r_reg.we;
    assign link.addr = r_reg.addr;
    assign link.wdata = r_reg.wdata;

endmodule : bda_host
`default_nettype wire

//--- verification/bda_checker.sv
// Assertions on the byte command link between host and device
`timescale 1ns/1ps
`default_nettype none
module bda_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic [7:0] rdata
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    // A request that is still waiting for its answer
    sequence s_wait;
        req && !ack;
    endsequence
    // The answer, then the host lets go
    sequence s_done;
        ack ##1 !ack && !req;
    endsequence
    a_ack_pulse: assert property (ack |=> !ack)
        else $error("ack held longer than one cycle");
    a_ack_in_req: assert property (ack |-> req)
        else $error("ack without a pending request");
    a_req_holds: assert property (s_wait |=> req && $stable(addr)
        && $stable(we) && $stable(wdata)) else $error("request changed early");
    a_req_drops: assert property (ack |-> s_done)
        else $error("request not dropped after ack");
    a_rsv_zero: assert property (ack && !we && addr >= 8'h62
        && addr <= 8'h7F |-> rdata == 8'h00) else $error("reserved read not 0");
    a_read_bound: assert property (s_wait and !we |-> ##[1:300] ack)
        else $error("read never answered");
    a_write_bound: assert property (s_wait and we |-> ##[1:300] ack)
        else $error("write never answered");
    // Read data is a register: it only moves with an answer
    a_rdata_holds: assert property (!ack |-> $stable(rdata))
        else $error("rdata changed without ack");
endmodule : bda_checker
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench: Wishbone host end driving the window device end
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 0, rst_i = 1, cs = 0, we = 0, ack, sl;
    logic [7:0] adr = 0, s;
    logic [31:0] dat = 0, rd, wdo, key;
    logic [7:0] win [32];
    int failures = 0, total_checks = 0;
    bda_link_if lnk ();
    bda_host i_bda_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1),
        .wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
        .link(lnk));
    // Short seal delay keeps the run brief
    bda_device #(.SEAL_CYCLES(20)) i_bda_device (.clk_i(clk_i),
        .rst_i(rst_i), .ce_i(1'h1), .link(lnk), .sealed_o(sl), .busy_o());
    bda_checker i_bda_checker (.clk_i(clk_i), .rst_i(rst_i), .req(lnk.req),
        .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack),
        .rdata(lnk.rdata));
    always #5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] v, input logic [7:0] e);
        total_checks++;
        if (v !== e)
        begin
            failures++;
            $display("unexpected at %0t: seen %h, expected %h", $time, v, e);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up
    // Classic cycle, entered just after a rising edge; a hang ends the run
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cs <= 1'h1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'h1 && ++n < 99);
        rd = wdo;
        cs <= 1'h0;
        @(posedge clk_i);
        failures += n >= 99;
        if (n >= 99) wrap_up();
    endtask : wb
    // Queue one link operation, then poll until the host is idle
    task automatic op(input logic [2:0] o, input logic [7:0] a,
        input logic [7:0] b, input logic [15:0] w = 16'h0);
        int n;
        n = 0;
        wb(1'h1, bda_pkg::HR_DATA, {w, b, a});
        wb(1'h1, bda_pkg::HR_CTRL, {23'h0, 1'h1, 5'h0, o});
        do wb(1'h0, bda_pkg::HR_STAT, 32'h0); while (rd[0] !== 1'h0 && ++n < 400);
        failures += n >= 400;
        if (n >= 400) wrap_up();
    endtask : op
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        op(3'h1, a, 8'h0);
        chk(rd[15:8], e);
    endtask : rdchk
    // Select, load, rewrite all 32 bytes, commit, reload and compare
    task automatic fill(input logic [7:0] c, input logic [7:0] k);
        op(3'h0, bda_pkg::CMD_CLASS, c);
        op(3'h0, bda_pkg::CMD_BLOCK, k);
        op(3'h0, bda_pkg::CMD_ACC, bda_pkg::ACC_ENABLE_CODE);
        s = 8'h0;
        for (int i = 0; i < 32; i++) op(3'h0, {3'h2, i[4:0]}, win[i]);
        foreach (win[i]) s = s + win[i];
        rdchk(bda_pkg::CMD_CSUM, 8'hFF - s);
        op(3'h2, bda_pkg::CMD_CSUM, 8'h0);
        op(3'h0, bda_pkg::CMD_ACC, bda_pkg::ACC_ENABLE_CODE);
        for (int i = 0; i < 32; i++) rdchk({3'h2, i[4:0]}, win[i]);
    endtask : fill
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h77CF));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        key = $urandom() | 32'h0001_0001;
        foreach (win[i]) win[i] = i < 4 ? key[31 - 8 * i -: 8] : 8'h0;
        fill(bda_pkg::CLS_KEY, 8'h0);
        $display("key block committed");
        foreach (win[i]) win[i] = 8'($urandom());
        fill(bda_pkg::CLS_STATE, 8'h1);
        rdchk(bda_pkg::CMD_CLASS, bda_pkg::CLS_STATE);
        rdchk(bda_pkg::CMD_BLOCK, 8'h1);
        // One byte past the block size must void the whole write
        for (int i = 0; i < 33; i++)
            op(3'h0, {3'h2, i[4:0]}, i[4:0] != 0 ? 8'h5A : 8'h0);
        op(3'h2, bda_pkg::CMD_CSUM, 8'h0);
        op(3'h0, bda_pkg::CMD_ACC, bda_pkg::ACC_ENABLE_CODE);
        rdchk(8'h40, win[0]);
        for (int a = 8'h62; a < 8'h80; a++) rdchk(a[7:0], 8'h0);
        $display("data block and reserved range done");
        foreach (win[i]) win[i] = i < 8 ? 8'($urandom()) : 8'h0;
        fill(bda_pkg::CLS_MAKER, 8'h0);
        op(3'h4, 8'h0, 8'h0, bda_pkg::SUB_SEAL);
        repeat (30) @(posedge clk_i);
        rdchk(bda_pkg::CMD_CTL_HI, 8'h20);
        chk(sl, 1'h1);
        rdchk(bda_pkg::CMD_CLASS, 8'h0);
        op(3'h0, bda_pkg::CMD_BLOCK, bda_pkg::MAKER_BLOCK_CODE);
        op(3'h0, 8'h40, ~win[0]);
        for (int i = 0; i < 8; i++) rdchk({3'h2, i[4:0]}, win[i]);
        rdchk(bda_pkg::CMD_CSUM, 8'hFF - s);
        $display("locked window done");
        wb(1'h1, bda_pkg::HR_KEY, ~key);
        op(3'h3, 8'h0, 8'h0);
        rdchk(bda_pkg::CMD_CTL_HI, 8'h20);
        wb(1'h1, bda_pkg::HR_KEY, key);
        op(3'h3, 8'h0, 8'h0);
        rdchk(bda_pkg::CMD_CTL_HI, 8'h00);
        chk(sl, 1'h0);
        $display("unlock sequence done");
        wrap_up();
    end
endmodule : tb
`default_nettype wire
